// [rtl/lcd_vt_pkg.sv]
// constants, register map and timing for the lcd voltage and temperature control block
`default_nettype none
package lcd_vt_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_offset    = 8'h00;
  localparam logic [7:0] voltage_offset = 8'h04;
  localparam logic [7:0] tcomp_offset   = 8'h08;
  localparam logic [7:0] temp_offset    = 8'h0C;
  localparam logic [7:0] status_offset  = 8'h10;
  localparam logic [7:0] sample_offset  = 8'h14;
  // control field positions
  localparam int pump_enable_bit       = 0;
  localparam int pump_multiplier_bit   = 1;
  localparam int pump_frequency_bit    = 2;
  localparam int external_supply_bit   = 3;
  localparam int measurement_bit       = 4;
  localparam int filter_bit            = 5;
  localparam int compensation_bit      = 6;
  localparam int frame_rate_lsb        = 8;
  // reset values
  localparam logic [7:0]  ctrl_reset           = 8'h00;
  localparam logic [7:0]  voltage_reset        = 8'h00;
  localparam logic [7:0]  temp_reset           = 8'h40;
  localparam logic [7:0]  slope_reset          = 8'h00;
  localparam logic [4:0]  frame_reset          = 5'h00;
  // voltage scaling in millivolts
  localparam int base_mv  = 3000;
  localparam int step_mv  = 30;
  localparam int limit_mv = 9000;
  localparam logic [7:0] limit_code = 8'((limit_mv - base_mv) / step_mv);
  // timing
  localparam int clock_hz       = 100_000_000;
  localparam int conversion_us  = 5000;
  localparam int conversion_cycles = conversion_us * (clock_hz / 1_000_000);
  localparam int frame_divider  = 48;
  localparam int frames_per_update = 200;
  localparam int filter_shift   = 2;
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  // temperature unit sequence
  typedef enum logic [1:0] {meas_idle, meas_convert, meas_wait} meas_state_t;
endpackage : lcd_vt_pkg
`default_nettype wire

// [rtl/pump_clock_gen.sv]
// glitch free pump clock generator with full and half rate
`default_nettype none
module pump_clock_gen #(
  parameter int half_period = 50
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clk_en,
  // controls
  input  wire logic run,
  input  wire logic half_rate,
  // pump phase
  output logic      pump_phase
);
  localparam int cw = $clog2(2 * half_period + 1);
  logic [cw-1:0] count;
  logic          slow;

  // rate is resampled only while stopped or when the high phase ends, so no shortened pulse appears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count      <= '0;
      pump_phase <= 1'b0;
      slow       <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        count      <= '0;
        pump_phase <= 1'b0;
        slow       <= half_rate;
      end else if (count >= cw'(slow ? 2 * half_period - 1 : half_period - 1)) begin
        count      <= '0;
        pump_phase <= ~pump_phase;
        if (pump_phase) begin
          slow <= half_rate;
        end
      end else begin
        count <= count + cw'(1);
      end
    end
  end
endmodule : pump_clock_gen
`default_nettype wire

// [rtl/lcd_vt_ctrl.sv]
// lcd drive voltage generation control and temperature measurement with axi4-lite registers
`default_nettype none
// Overview of operation
// - pump runs only while enable set
// - multiplier zero doubles, one triples
// - setting is programmed value plus offset
// - each code adds 30 mV over 3 V
// - offset is signed, zero at 20 C
// - every programmed code is accepted
// - drive voltage limited to 9.0 V
// - external supply ignores compensation and code
// - frequency bit selects full or half rate
// - 8-bit temperature readable by host
// - temperature is 0.9375 code minus 40
// - conversion takes about 5 ms
// - conversions repeat while measurement enabled
// - interval derived from frame clock
// - filter enable, resets off, raw used
// - temperature resets to 20 C code
// - compensation only while enable set
// - temperature code resets to 40h
// - sum saturates at 8-bit range ends
module lcd_vt_ctrl
  import lcd_vt_pkg::*;
#(
  parameter int conv_cycles = lcd_vt_pkg::conversion_cycles,
  parameter int pump_half_period = 50,
  parameter int update_frames = lcd_vt_pkg::frames_per_update
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // frame tick and sensor
  input  wire logic        frame_clk_pin,
  input  wire logic [7:0]  sensor_code,
  output logic             sensor_start,
  // pump and analog outputs
  output logic             pump_phase,
  output logic             pump_multiplier_select,
  output logic [7:0]       lcd_drive_voltage
);
  import lcd_vt_pkg::*;

  // -----------------------------------------------
  // register state
  // -----------------------------------------------
  logic [15:0] ctrl;
  logic [7:0]  programmed_voltage_code;
  logic [7:0]  temperature_offset_term;
  logic [7:0]  temperature_code;
  logic [7:0]  raw_sample;
  logic        pump_enable;
  logic        pump_frequency_select;
  logic        external_supply;
  logic        measurement_enable;
  logic        temperature_filter_enable;
  logic        compensation_enable;
  logic        busy;

  assign pump_enable               = ctrl[pump_enable_bit];
  assign pump_frequency_select     = ctrl[pump_frequency_bit];
  assign external_supply           = ctrl[external_supply_bit];
  assign measurement_enable        = ctrl[measurement_bit];
  assign temperature_filter_enable = ctrl[filter_bit];
  assign compensation_enable       = ctrl[compensation_bit];

  // -----------------------------------------------
  // axi4-lite write channel
  // -----------------------------------------------
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // address and data are caught separately, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == ctrl_offset || aw_addr == voltage_offset || aw_addr == tcomp_offset
            || aw_addr == temp_offset || aw_addr == status_offset || aw_addr == sample_offset) begin
          s_axi_bresp <= resp_okay;
        end else begin
          s_axi_bresp <= resp_slverr;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control and programmed value registers
  // pump enable and multiplier take effect next edge, frequency at the end of the next high pump phase, or at once while the pump is stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl                    <= {3'b000, frame_reset, ctrl_reset};
      programmed_voltage_code <= voltage_reset;
      temperature_offset_term <= slope_reset;
    end else if (clk_en && do_write) begin
      if (aw_addr == ctrl_offset) begin
        if (w_strb[0]) ctrl[7:0]  <= w_data[7:0];
        if (w_strb[1]) ctrl[15:8] <= {3'b000, w_data[12:8]};
      end else if (aw_addr == voltage_offset) begin
        if (w_strb[0]) programmed_voltage_code <= w_data[7:0];
      end else if (aw_addr == tcomp_offset) begin
        // signed offset from the slope logic
        if (w_strb[0]) temperature_offset_term <= w_data[7:0];
      end
    end
  end

  // -----------------------------------------------
  // axi4-lite read channel
  // -----------------------------------------------
  logic [31:0] read_word;

  always_comb begin
    if (s_axi_araddr == ctrl_offset) begin
      read_word = {16'h0000, ctrl};
    end else if (s_axi_araddr == voltage_offset) begin
      read_word = {24'h00_0000, programmed_voltage_code};
    end else if (s_axi_araddr == tcomp_offset) begin
      read_word = {24'h00_0000, temperature_offset_term};
    end else if (s_axi_araddr == temp_offset) begin
      read_word = {24'h00_0000, temperature_code};
    end else if (s_axi_araddr == status_offset) begin
      read_word = {23'h00_0000, busy, lcd_drive_voltage};
    end else if (s_axi_araddr == sample_offset) begin
      read_word = {24'h00_0000, raw_sample};
    end else begin
      read_word = 32'h0000_0000;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= resp_okay;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word;
        s_axi_rresp  <= (read_word == 32'h0000_0000 && s_axi_araddr > sample_offset) ? resp_slverr : resp_okay;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // -----------------------------------------------
  // frame tick synchroniser and update interval
  // -----------------------------------------------
  logic        frame_meta;
  logic        frame_sync;
  logic        frame_prev;
  logic [15:0] frame_count;
  logic        interval_due;

  // frame tick comes from the oscillator domain, so two flops first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_meta <= 1'b0;
      frame_sync <= 1'b0;
      frame_prev <= 1'b0;
    end else if (clk_en) begin
      frame_meta <= frame_clk_pin;
      frame_sync <= frame_meta;
      frame_prev <= frame_sync;
    end
  end

  // interval counted in frames, so it scales with frame rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_count  <= 16'h0000;
      interval_due <= 1'b0;
    end else if (clk_en) begin
      interval_due <= 1'b0;
      if (!measurement_enable) begin
        frame_count <= 16'h0000;
      end else if (frame_sync && !frame_prev) begin
        if (frame_count >= 16'(update_frames - 1)) begin
          frame_count  <= 16'h0000;
          interval_due <= 1'b1;
        end else begin
          frame_count <= frame_count + 16'h0001;
        end
      end
    end
  end

  // -----------------------------------------------
  // temperature conversion sequence
  // -----------------------------------------------
  meas_state_t state;
  logic [31:0] conv_count;
  logic        sample_ready;

  assign busy = (state != meas_idle);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state        <= meas_idle;
      conv_count   <= 32'h0000_0000;
      sensor_start <= 1'b0;
      sample_ready <= 1'b0;
      raw_sample   <= temp_reset;
    end else if (clk_en) begin
      sensor_start <= 1'b0;
      sample_ready <= 1'b0;
      case (state)
        meas_idle: begin
          if (measurement_enable) begin
            state        <= meas_convert;
            sensor_start <= 1'b1;
            conv_count   <= 32'h0000_0000;
          end
        end
        meas_convert: begin
          if (conv_count >= 32'(conv_cycles - 1)) begin
            raw_sample   <= sensor_code;
            sample_ready <= 1'b1;
            state        <= meas_wait;
          end else begin
            conv_count <= conv_count + 32'h0000_0001;
          end
        end
        meas_wait: begin
          if (!measurement_enable) begin
            state <= meas_idle;
          end else if (interval_due) begin
            state        <= meas_convert;
            sensor_start <= 1'b1;
            conv_count   <= 32'h0000_0000;
          end
        end
        default: state <= meas_idle;
      endcase
    end
  end

  // code scale is fixed by the sensor, stored as delivered
  // filter steps a quarter toward each reading
  logic signed [9:0] filter_delta;
  assign filter_delta = $signed({2'b00, raw_sample}) - $signed({2'b00, temperature_code});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temperature_code <= temp_reset;
    end else if (clk_en && sample_ready) begin
      if (temperature_filter_enable) begin
        temperature_code <= 8'($signed({2'b00, temperature_code}) + (filter_delta >>> filter_shift)
                               + ((filter_delta != 10'sd0 && (filter_delta >>> filter_shift) == 10'sd0)
                                  ? (filter_delta > 0 ? 10'sd1 : -10'sd1) : 10'sd0));
      end else begin
        temperature_code <= raw_sample;
      end
    end
  end

  // -----------------------------------------------
  // voltage code
  // -----------------------------------------------
  logic signed [9:0] sum;
  logic [7:0]        next_code;

  // saturating sum, offset only when compensation on
  always_comb begin
    sum = $signed({2'b00, programmed_voltage_code})
        + (compensation_enable ? $signed({{2{temperature_offset_term[7]}}, temperature_offset_term}) : 10'sd0);
    if (sum < 10'sd0) begin
      next_code = 8'h00;
    end else if (sum > 10'sd255) begin
      next_code = 8'hFF;
    end else begin
      next_code = sum[7:0];
    end
  end

  // code is 3 V plus 30 mV steps, clamped at 9.0 V
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcd_drive_voltage      <= voltage_reset;
      pump_multiplier_select <= 1'b0;
    end else if (clk_en) begin
      pump_multiplier_select <= ctrl[pump_multiplier_bit];
      if (external_supply) begin
        lcd_drive_voltage <= 8'h00;
      end else if (next_code > limit_code) begin
        lcd_drive_voltage <= limit_code;
      end else begin
        lcd_drive_voltage <= next_code;
      end
    end
  end

  pump_clock_gen #(
    .half_period (pump_half_period)
  ) pump_clk (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clk_en     (clk_en),
    .run        (pump_enable && !external_supply),
    .half_rate  (pump_frequency_select),
    .pump_phase (pump_phase)
  );

  // -----------------------------------------------
  // checks
  // -----------------------------------------------
  chk_clamp_limit: assert property (@(posedge aclk) disable iff (!aresetn) lcd_drive_voltage <= limit_code)
    else $error("drive code above limit");
  chk_pump_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pump_enable && clk_en) [*3] |-> !pump_phase)
    else $error("pump toggles while disabled");
  chk_external_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (external_supply && clk_en) |=> lcd_drive_voltage == 8'h00)
    else $error("code driven with external supply");
  chk_no_comp: assert property (@(posedge aclk) disable iff (!aresetn)
    (!compensation_enable && !external_supply && clk_en && programmed_voltage_code <= limit_code)
    |=> lcd_drive_voltage == $past(programmed_voltage_code))
    else $error("offset applied while compensation off");
  chk_saturate_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (sum < 10'sd0) |-> next_code == 8'h00)
    else $error("sum wrapped below zero");
  chk_conv_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && state == meas_idle && measurement_enable) |=> sensor_start && state == meas_convert)
    else $error("conversion not started");
  chk_raw_path: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && sample_ready && !temperature_filter_enable) |=> temperature_code == $past(raw_sample))
    else $error("raw reading not used");
  chk_mult_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> pump_multiplier_select == $past(ctrl[pump_multiplier_bit]))
    else $error("multiplier not following control");
endmodule : lcd_vt_ctrl
`default_nettype wire

// [bench/temp_sensor_model.sv]
// behavioural temperature sensor and frame oscillator facing the control block
`default_nettype none
module temp_sensor_model #(
  parameter int conv_cycles = 20,
  parameter int frame_half  = 8
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // conversion handshake
  input  wire logic       sensor_start,
  input  wire logic [7:0] reading,
  output logic [7:0]      sensor_code,
  // frame tick
  output logic            frame_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold;
  int fcnt;
  // result is valid only through the conversion window; outside it the code churns every cycle
  // so a late sample shows up as a wrong value rather than a lucky match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold <= 0;
      sensor_code <= 8'h00;
    end else if (sensor_start || hold > 0) begin
      hold <= sensor_start ? conv_cycles + 3 : hold - 1;
      sensor_code <= reading;
    end else begin
      sensor_code <= ~sensor_code;
    end
  end
  // free running frame oscillator, square wave of 2*frame_half cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcnt <= 0;
      frame_clk_pin <= 1'b0;
    end else if (fcnt == frame_half - 1) begin
      fcnt <= 0;
      frame_clk_pin <= ~frame_clk_pin;
    end else begin
      fcnt <= fcnt + 1;
    end
  end
endmodule : temp_sensor_model
`default_nettype wire

// [bench/tb_lcd_voltage_and_temp_control.sv]
// self-checking bench for the lcd voltage and temperature control block
`default_nettype none
module tb_lcd_voltage_and_temp_control;
  import lcd_vt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int conv       = 20;
  localparam int half       = 2;
  localparam int frames     = 3;
  localparam int frame_half = 8;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        frame_clk_pin, sensor_start, pump_phase, pump_multiplier_select, last_phase, clk_en;
  logic [7:0]  sensor_code, lcd_drive_voltage, reading;
  int          mismatches, compares, starts, last_start, gap, cyc, toggles;

  lcd_vt_ctrl #(.conv_cycles(conv), .pump_half_period(half), .update_frames(frames)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frame_clk_pin(frame_clk_pin),
    .sensor_code(sensor_code), .sensor_start(sensor_start), .pump_phase(pump_phase),
    .pump_multiplier_select(pump_multiplier_select), .lcd_drive_voltage(lcd_drive_voltage));

  temp_sensor_model #(.conv_cycles(conv), .frame_half(frame_half)) i_sensor (
    .aclk(aclk), .aresetn(aresetn), .sensor_start(sensor_start), .reading(reading),
    .sensor_code(sensor_code), .frame_clk_pin(frame_clk_pin));

  // pump edges and conversion starts, counted for the scenarios
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    last_phase <= pump_phase;
    if (pump_phase !== last_phase) toggles <= toggles + 1;
    if (sensor_start === 1'b1) begin
      starts <= starts + 1;
      gap <= cyc - last_start;
      last_start <= cyc;
    end
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // bready stays high throughout, so one write never races the next
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    bit aw_left, w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (aw_left && s_axi_awready === 1'b1) begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1) begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    check("write resp", 32'(addr < 8'h0c ? resp_okay : resp_slverr), 32'(s_axi_bresp));
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    data = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd

  task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(addr, d, r);
    check("read data", exp, d);
    check("read resp", 32'(resp_okay), 32'(r));
  endtask : rd_check

  task automatic wait_start(input int lim);
    int s;
    int n;
    s = starts;
    n = 0;
    while (starts == s && n < lim) begin
      @(posedge aclk);
      n++;
    end
    check("conversion started", 32'h0000_0001, 32'(n < lim));
  endtask : wait_start

  // saturate to the byte range first, then apply the 9.0 V ceiling
  function automatic logic [31:0] exp_code(input logic [7:0] p, input logic [7:0] o, input bit c);
    int s;
    s = int'(p) + (c ? int'($signed(o)) : 0);
    if (s < 0) s = 0;
    if (s > 255) s = 255;
    if (s > int'(limit_code)) s = int'(limit_code);
    return 32'(s);
  endfunction : exp_code
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd_check(temp_offset, 32'h0000_0040);
    rd_check(sample_offset, 32'h0000_0040);
    rd_check(ctrl_offset, 32'h0000_0000);
    check("reset code", 32'h0000_0000, 32'(lcd_drive_voltage));
    check("reset phase", 32'h0000_0000, 32'(pump_phase));
    rd(8'h18, d, r);
    check("unmapped data", 32'h0000_0000, d);
    check("unmapped resp", 32'(resp_slverr), 32'(r));
    wr(8'h1c, 32'h0000_0001);
    rd_check(ctrl_offset, 32'h0000_0000);
  endtask : test_reset

  task automatic test_voltage();
    logic [7:0]  pv [10] = '{8'h10, 8'h10, 8'h10, 8'h05, 8'hff, 8'hc7, 8'hc7, 8'h64, 8'hf0, 8'h00};
    logic [7:0]  ov [10] = '{8'h05, 8'h05, 8'hf0, 8'hf0, 8'h00, 8'h01, 8'h00, 8'h7f, 8'h20, 8'h00};
    bit          cv [10] = '{1, 0, 1, 1, 0, 1, 1, 1, 1, 0};
    logic [31:0] d;
    logic [1:0]  r;
    // the bench stands for a pump supply of 3.0 V or less
    for (int i = 0; i < 10; i++) begin
      wr(tcomp_offset, 32'(ov[i]));
      wr(voltage_offset, 32'(pv[i]));
      wr(ctrl_offset, 32'(cv[i]) << compensation_bit);
      repeat (2) @(posedge aclk);
      check("drive code", exp_code(pv[i], ov[i], cv[i]), 32'(lcd_drive_voltage));
      rd(status_offset, d, r);
      check("status code", exp_code(pv[i], ov[i], cv[i]), 32'(d[7:0]));
    end
  endtask : test_voltage

  task automatic test_external();
    // pump enable stays clear here, so the phase check only sees a pump that is already stopped
    wr(ctrl_offset, 32'h0000_0048);
    wr(tcomp_offset, 32'h0000_0010);
    wr(voltage_offset, 32'h0000_0060);
    repeat (2) @(posedge aclk);
    check("external code", 32'h0000_0000, 32'(lcd_drive_voltage));
    check("external phase", 32'h0000_0000, 32'(pump_phase));
  endtask : test_external

  task automatic test_pump();
    logic [31:0] ctl [3] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0005};
    int          exp [3] = '{0, 40 / half, 20 / half};
    int          t;
    for (int i = 0; i < 3; i++) begin
      wr(ctrl_offset, ctl[i]);
      repeat (5) @(posedge aclk);
      t = toggles;
      repeat (40) @(posedge aclk);
      t = toggles - t - exp[i];
      check("pump edges", 32'h0000_0001, 32'(t <= 1 && t >= -1));
    end
    // clock enable low must freeze the running pump
    clk_en <= 1'b0;
    t = toggles;
    repeat (12) @(posedge aclk);
    check("frozen pump", 32'h0000_0001, 32'(toggles - t <= 1));
    clk_en <= 1'b1;
    // frequency bit is left at zero from here on
    wr(ctrl_offset, 32'h0000_0003);
    repeat (2) @(posedge aclk);
    check("triple", 32'h0000_0001, 32'(pump_multiplier_select));
    wr(ctrl_offset, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    check("double", 32'h0000_0000, 32'(pump_multiplier_select));
    check("stopped", 32'h0000_0000, 32'(pump_phase));
  endtask : test_pump

  task automatic test_temperature();
    logic [31:0] d;
    logic [1:0]  r;
    int          s;
    reading <= 8'h55;
    wr(ctrl_offset, 32'h0000_0010);
    wait_start(20);
    rd_check(temp_offset, 32'h0000_0040);
    rd(status_offset, d, r);
    check("busy", 32'h0000_0001, 32'(d[8]));
    repeat (conv + 4) @(posedge aclk);
    rd_check(temp_offset, 32'h0000_0055);
    rd_check(sample_offset, 32'h0000_0055);
    wait_start(100);
    wait_start(100);
    s = gap - frames * 2 * frame_half;
    check("interval", 32'h0000_0001, 32'(s <= 1 && s >= -1));
    wr(ctrl_offset, 32'h0000_0030);
    reading <= 8'h95;
    wait_start(100);
    repeat (conv + 4) @(posedge aclk);
    rd(temp_offset, d, r);
    check("filtered step", 32'h0000_0001, 32'(d > 32'h55 && d < 32'h95));
    repeat (2500) @(posedge aclk);
    rd_check(temp_offset, 32'h0000_0095);
    wr(ctrl_offset, 32'h0000_0000);
    // a start launched on the disabling edge is still being counted
    repeat (2) @(posedge aclk);
    s = starts;
    repeat (200) @(posedge aclk);
    check("no conversions", 32'(s), 32'(starts));
  endtask : test_temperature

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ready lines stay high: the bench accepts every answer at once
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    reading = 8'h55;
    {mismatches, compares, starts, last_start, gap, cyc, toggles} = '0;
    {last_phase, clk_en} = 2'b01;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset();
    test_voltage();
    test_external();
    test_pump();
    test_temperature();
    test_done();
  end

  // the run needs under 6000 cycles; cut a hang well after that
  initial begin
    #200_000;
    mismatches++;
    test_done();
  end
endmodule : tb_lcd_voltage_and_temp_control
`default_nettype wire
